// ==== ptsc_pkg.sv ====
package ptsc_pkg;
	// register indices on the byte-wide control port
	localparam logic [3:0] PTSC_ADR_CTRL1 = 4'h0;
	localparam logic [3:0] PTSC_ADR_CTRL2 = 4'h1;
	localparam logic [3:0] PTSC_ADR_CTRL3 = 4'h2;
	localparam logic [3:0] PTSC_ADR_PER_LO = 4'h3;
	localparam logic [3:0] PTSC_ADR_PER_HI = 4'h4;
	localparam logic [3:0] PTSC_ADR_WID_LO = 4'h5;
	localparam logic [3:0] PTSC_ADR_WID_HI = 4'h6;
	localparam logic [3:0] PTSC_ADR_RISE_LO = 4'h8;
	localparam logic [3:0] PTSC_ADR_RISE_HI = 4'h9;
	localparam logic [3:0] PTSC_ADR_FALL_LO = 4'ha;
	localparam logic [3:0] PTSC_ADR_FALL_HI = 4'hb;

	// first control register fields
	localparam int PTSC_C1_SRC_LSB = 0;
	localparam int PTSC_C1_EDGE = 2;
	localparam int PTSC_C1_ACCEPT = 3;
	localparam int PTSC_C1_INIT_A = 4;
	localparam int PTSC_C1_INIT_B = 5;
	// second control register fields
	localparam int PTSC_C2_EN_A = 0;
	localparam int PTSC_C2_EN_B = 1;
	// third control register fields
	localparam int PTSC_C3_RUN = 0;
	localparam int PTSC_C3_STM_LSB = 1;
	localparam int PTSC_C3_BUSY = 7;

	localparam logic [7:0] PTSC_CTRL1_RST = 8'h00;
	localparam logic [7:0] PTSC_CTRL2_RST = 8'h03;
	localparam logic [9:0] PTSC_PERIOD_RST = 10'h3ff;
	localparam logic [9:0] PTSC_WIDTH_RST = 10'h200;
	localparam logic [9:0] PTSC_ZERO10 = 10'h000;
	localparam logic [10:0] PTSC_FULL_PERIOD = 11'h400;
	localparam logic [7:0] PTSC_ZERO8 = 8'h00;

	typedef enum logic [1:0] {
		PTSC_SRC_CMD_CAP = 2'b00,
		PTSC_SRC_CMD_TRIG = 2'b01,
		PTSC_SRC_TRIG = 2'b10,
		PTSC_SRC_RSVD = 2'b11
	} ptsc_src_e;

	typedef enum logic [1:0] {
		PTSC_STM_INIT = 2'b00,
		PTSC_STM_HOLD = 2'b01,
		PTSC_STM_END = 2'b10,
		PTSC_STM_RSVD = 2'b11
	} ptsc_stm_e;
endpackage

// ==== ptsc_sync.sv ====
`timescale 1ns/1ps
`default_nettype none
module ptsc_sync (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic pin,
	output logic level,
	output logic rise,
	output logic fall
);
	logic meta_r;
	logic sync_r;
	logic last_r;

	// second stage and edge history only; first stage feeds nothing else
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			meta_r <= 1'b0;
			sync_r <= 1'b0;
			last_r <= 1'b0;
		end else begin
			meta_r <= pin;
			sync_r <= meta_r;
			last_r <= sync_r;
		end
	end

	assign level = sync_r;
	assign rise = sync_r & ~last_r;
	assign fall = ~sync_r & last_r;
endmodule
`default_nettype wire

// ==== ptsc_top.sv ====
`timescale 1ns/1ps
`default_nettype none
module ptsc_top #(
	parameter int CNT_W = 10
) (
	input wire logic SYS_CLK,
	input wire logic RST_N,
	input wire logic [3:0] ADDR,
	input wire logic [7:0] WDATA,
	input wire logic WR,
	input wire logic RD,
	output logic [7:0] RDATA,
	input wire logic TRIG_PIN,
	output logic PULSE_A,
	output logic PULSE_B,
	output logic PERIOD_IRQ,
	output logic TRIG_START_IRQ
);
	import ptsc_pkg::*;

	initial begin
		if (CNT_W != 10) begin
			$error("ptsc_top: counter width must be 10");
		end
	end

	////////////////////////////////////////////////////////////////////
	logic trig_lvl, trig_rise, trig_fall;
	logic [7:0] ctrl1_r;
	logic [7:0] ctrl2_r;
	logic run_r;
	logic [1:0] stm_r;
	logic [9:0] period_r;
	logic [9:0] width_r;
	logic [9:0] cnt_r;
	logic counting_r;
	logic pending_r;
	logic hold_r;
	logic prot_r;
	logic [9:0] buf_rise_r, buf_fall_r;
	logic [9:0] cap_rise_r, cap_fall_r;
	logic [7:0] RDATA_nxt;

	ptsc_sync u_sync (
		.clk(SYS_CLK),
		.rst_n(RST_N),
		.pin(TRIG_PIN),
		.level(trig_lvl),
		.rise(trig_rise),
		.fall(trig_fall)
	);

	function automatic logic hit(input logic [3:0] a, input logic [3:0] r);
		hit = (a == r);
	endfunction

	////////////////////////////////////////////////////////////////////
	ptsc_src_e src;
	logic edge_sel, accept_mode, init_a, init_b, en_a, en_b;
	assign src = ptsc_src_e'(ctrl1_r[PTSC_C1_SRC_LSB +: 2]);
	assign edge_sel = ctrl1_r[PTSC_C1_EDGE];
	assign accept_mode = ctrl1_r[PTSC_C1_ACCEPT];
	assign init_a = ctrl1_r[PTSC_C1_INIT_A];
	assign init_b = ctrl1_r[PTSC_C1_INIT_B];
	assign en_a = ctrl2_r[PTSC_C2_EN_A];
	assign en_b = ctrl2_r[PTSC_C2_EN_B];

	logic trig_mode, cap_mode;
	logic start_edge, stop_level;
	logic act_a, act_b, gate_ok, trig_live;
	logic [10:0] period_eff;
	logic period_end;
	logic wr_c3, cmd_start, cmd_stop;

	assign trig_mode = (src != PTSC_SRC_CMD_CAP);
	assign cap_mode = (src == PTSC_SRC_CMD_CAP);
	// edge select 1 starts on rising, stops while low; 0 is the mirror
	assign start_edge = edge_sel ? trig_rise : trig_fall;
	assign stop_level = edge_sel ? ~trig_lvl : trig_lvl;
	// a disabled output never counts as active
	assign act_a = counting_r & en_a & ({1'b0, cnt_r} < {1'b0, width_r});
	assign act_b = counting_r & en_b & ({1'b0, cnt_r} >= {1'b0, width_r});
	assign gate_ok = ~accept_mode | ~(act_a | act_b);
	assign trig_live = (run_r | pending_r) & trig_mode;
	// a period of zero stands for the full 10-bit range
	assign period_eff = (period_r == PTSC_ZERO10) ? PTSC_FULL_PERIOD :
		{1'b0, period_r};
	assign period_end = counting_r &
		({1'b0, cnt_r} == period_eff - 11'h001);
	assign wr_c3 = WR & hit(ADDR, PTSC_ADR_CTRL3);
	assign cmd_start = wr_c3 & WDATA[PTSC_C3_RUN];
	assign cmd_stop = wr_c3 & ~WDATA[PTSC_C3_RUN] & run_r;

	logic trig_stop, trig_start;
	assign trig_stop = trig_live & stop_level & gate_ok &
		(counting_r | pending_r);
	assign trig_start = trig_live & ~pending_r & ~counting_r & start_edge &
		gate_ok;

	////////////////////////////////////////////////////////////////////
	// configuration registers
	always_ff @(posedge SYS_CLK) begin
		if (!RST_N) begin
			ctrl1_r <= PTSC_CTRL1_RST;
			ctrl2_r <= PTSC_CTRL2_RST;
			period_r <= PTSC_PERIOD_RST;
			width_r <= PTSC_WIDTH_RST;
			stm_r <= PTSC_STM_INIT;
		end else if (WR) begin
			if (hit(ADDR, PTSC_ADR_CTRL1)) begin
				ctrl1_r <= WDATA;
			end else if (hit(ADDR, PTSC_ADR_CTRL2)) begin
				ctrl2_r <= WDATA;
			end else if (hit(ADDR, PTSC_ADR_CTRL3)) begin
				stm_r <= WDATA[PTSC_C3_STM_LSB +: 2];
			end else if (hit(ADDR, PTSC_ADR_PER_LO)) begin
				period_r[7:0] <= WDATA;
			end else if (hit(ADDR, PTSC_ADR_PER_HI)) begin
				period_r[9:8] <= WDATA[1:0];
			end else if (hit(ADDR, PTSC_ADR_WID_LO)) begin
				width_r[7:0] <= WDATA;
			end else if (hit(ADDR, PTSC_ADR_WID_HI)) begin
				width_r[9:8] <= WDATA[1:0];
			end
		end
	end

	// run bit follows CTRL3 writes only, so a one-time stop clears it before period end
	always_ff @(posedge SYS_CLK) begin
		if (!RST_N) begin
			run_r <= 1'b0;
		end else if (wr_c3) begin
			run_r <= WDATA[PTSC_C3_RUN];
		end
	end

	////////////////////////////////////////////////////////////////////
	// counter, running flag and deferred stop
	always_ff @(posedge SYS_CLK) begin
		if (!RST_N) begin
			cnt_r <= PTSC_ZERO10;
			counting_r <= 1'b0;
			pending_r <= 1'b0;
			hold_r <= 1'b0;
		end else if (cmd_stop) begin
			if (WDATA[PTSC_C3_STM_LSB +: 2] == PTSC_STM_END &&
				counting_r) begin
				pending_r <= 1'b1;
				cnt_r <= cnt_r + 10'h001;
			end else begin
				counting_r <= 1'b0;
				cnt_r <= PTSC_ZERO10;
				hold_r <= (WDATA[PTSC_C3_STM_LSB +: 2] == PTSC_STM_HOLD);
			end
		end else if (cmd_start && src != PTSC_SRC_TRIG) begin
			// trigger level beats the command when one is wired in
			cnt_r <= PTSC_ZERO10;
			counting_r <= ~(trig_mode & stop_level);
			pending_r <= 1'b0;
			hold_r <= 1'b0;
		end else if (trig_stop) begin
			cnt_r <= PTSC_ZERO10;
			counting_r <= 1'b0;
			pending_r <= 1'b0;
			hold_r <= 1'b0;
		end else if (trig_start) begin
			cnt_r <= PTSC_ZERO10;
			counting_r <= 1'b1;
			hold_r <= 1'b0;
		end else if (period_end) begin
			cnt_r <= PTSC_ZERO10;
			if (pending_r || stm_r == PTSC_STM_END) begin
				counting_r <= 1'b0;
				pending_r <= 1'b0;
			end
		end else if (counting_r) begin
			cnt_r <= cnt_r + 10'h001;
		end
	end

	////////////////////////////////////////////////////////////////////
	// interrupt pulses, one cycle each
	always_ff @(posedge SYS_CLK) begin
		if (!RST_N) begin
			PERIOD_IRQ <= 1'b0;
			TRIG_START_IRQ <= 1'b0;
		end else begin
			PERIOD_IRQ <= (cmd_start && src != PTSC_SRC_TRIG &&
				!(trig_mode && stop_level)) ||
				(period_end && !cmd_stop && !cmd_start && !trig_stop);
			TRIG_START_IRQ <= trig_start && !cmd_stop &&
				!(cmd_start && src != PTSC_SRC_TRIG);
		end
	end

	// positive logic when the initial-level bit is 0
	always_ff @(posedge SYS_CLK) begin
		if (!RST_N) begin
			PULSE_A <= 1'b0;
			PULSE_B <= 1'b0;
		end else if (!hold_r) begin
			PULSE_A <= init_a ^ act_a;
			PULSE_B <= init_b ^ act_b;
		end
	end

	////////////////////////////////////////////////////////////////////
	// capture: last edge in a period wins, buffer survives idle periods
	always_ff @(posedge SYS_CLK) begin
		if (!RST_N) begin
			buf_rise_r <= PTSC_ZERO10;
			buf_fall_r <= PTSC_ZERO10;
		end else if (cap_mode && run_r && counting_r) begin
			if (trig_rise) begin
				buf_rise_r <= cnt_r;
			end
			if (trig_fall) begin
				buf_fall_r <= cnt_r;
			end
		end
	end

	always_ff @(posedge SYS_CLK) begin
		if (!RST_N) begin
			cap_rise_r <= PTSC_ZERO10;
			cap_fall_r <= PTSC_ZERO10;
		end else if (period_end && !prot_r && run_r && cap_mode) begin
			cap_rise_r <= buf_rise_r;
			cap_fall_r <= buf_fall_r;
		end
	end

	// the pair is treated as one read set ending at the fall high byte
	always_ff @(posedge SYS_CLK) begin
		if (!RST_N) begin
			prot_r <= 1'b0;
		end else if (RD) begin
			if (hit(ADDR, PTSC_ADR_FALL_HI)) begin
				prot_r <= 1'b0;
			end else if (hit(ADDR, PTSC_ADR_RISE_LO) ||
				hit(ADDR, PTSC_ADR_RISE_HI) ||
				hit(ADDR, PTSC_ADR_FALL_LO)) begin
				prot_r <= 1'b1;
			end
		end
	end

	////////////////////////////////////////////////////////////////////
	// read port, data valid only in the cycle after the strobe
	always_comb begin
		RDATA_nxt = PTSC_ZERO8;
		if (hit(ADDR, PTSC_ADR_CTRL1)) begin
			RDATA_nxt = ctrl1_r;
		end else if (hit(ADDR, PTSC_ADR_CTRL2)) begin
			RDATA_nxt = ctrl2_r;
		end else if (hit(ADDR, PTSC_ADR_CTRL3)) begin
			RDATA_nxt[PTSC_C3_RUN] = run_r;
			RDATA_nxt[PTSC_C3_STM_LSB +: 2] = stm_r;
			RDATA_nxt[PTSC_C3_BUSY] = counting_r;
		end else if (hit(ADDR, PTSC_ADR_PER_LO)) begin
			RDATA_nxt = period_r[7:0];
		end else if (hit(ADDR, PTSC_ADR_PER_HI)) begin
			RDATA_nxt[1:0] = period_r[9:8];
		end else if (hit(ADDR, PTSC_ADR_WID_LO)) begin
			RDATA_nxt = width_r[7:0];
		end else if (hit(ADDR, PTSC_ADR_WID_HI)) begin
			RDATA_nxt[1:0] = width_r[9:8];
		end else if (hit(ADDR, PTSC_ADR_RISE_LO)) begin
			RDATA_nxt = cap_rise_r[7:0];
		end else if (hit(ADDR, PTSC_ADR_RISE_HI)) begin
			RDATA_nxt[1:0] = cap_rise_r[9:8];
		end else if (hit(ADDR, PTSC_ADR_FALL_LO)) begin
			RDATA_nxt = cap_fall_r[7:0];
		end else if (hit(ADDR, PTSC_ADR_FALL_HI)) begin
			RDATA_nxt[1:0] = cap_fall_r[9:8];
		end
	end

	always_ff @(posedge SYS_CLK) begin
		if (!RST_N) begin
			RDATA <= PTSC_ZERO8;
		end else begin
			RDATA <= RD ? RDATA_nxt : PTSC_ZERO8;
		end
	end

	////////////////////////////////////////////////////////////////////
	default clocking @(posedge SYS_CLK); endclocking
	default disable iff (!RST_N);

	cmd_start_a: assert property (
		cmd_start && src == PTSC_SRC_CMD_TRIG && !stop_level && !cmd_stop
		|=> counting_r && cnt_r == PTSC_ZERO10 && PERIOD_IRQ)
		else $error("command start did not start counter");

	start_blocked_a: assert property (
		cmd_start && src == PTSC_SRC_CMD_TRIG && stop_level
		|=> !counting_r && !PERIOD_IRQ)
		else $error("command start ran at stop level");

	trig_ignore_a: assert property (
		wr_c3 && src == PTSC_SRC_TRIG && !counting_r && !trig_start
		|=> !counting_r && $stable(hold_r))
		else $error("run write acted in trigger mode");

	trig_start_a: assert property (
		trig_start && !wr_c3 |=> counting_r && TRIG_START_IRQ)
		else $error("start edge did not start counter");

	level_stop_a: assert property (
		trig_live && stop_level && gate_ok && counting_r && !wr_c3
		|=> !counting_r ##1 !counting_r || trig_start)
		else $error("stop level did not stop counter");

	idle_ignore_a: assert property (
		!run_r && !pending_r && !counting_r && !WR |=> !counting_r)
		else $error("trigger accepted while stopped");

	gate_wait_a: assert property (
		accept_mode && (act_a || act_b) && counting_r && !wr_c3 &&
		!period_end |=> counting_r)
		else $error("trigger accepted while outputs active");

	stop_init_a: assert property (
		cmd_stop && WDATA[PTSC_C3_STM_LSB +: 2] == PTSC_STM_INIT
		##1 !WR[*2] |-> !counting_r && PULSE_A == init_a)
		else $error("stop mode 00 left outputs active");

	stop_hold_a: assert property (
		cmd_stop && WDATA[PTSC_C3_STM_LSB +: 2] == PTSC_STM_HOLD
		##1 !WR[*3] |-> $stable(PULSE_A) && $stable(PULSE_B))
		else $error("stop mode 01 changed outputs");

	defer_run_a: assert property (
		pending_r && !period_end && !trig_stop && !WR |=> counting_r)
		else $error("deferred stop ended early");

	protect_set_a: assert property (
		RD && hit(ADDR, PTSC_ADR_RISE_LO) |=> prot_r)
		else $error("capture read did not protect");

	protect_clr_a: assert property (
		RD && hit(ADDR, PTSC_ADR_FALL_HI) |=> !prot_r)
		else $error("fall high read did not release");

	cap_frozen_a: assert property (
		prot_r |=> $stable(cap_rise_r) && $stable(cap_fall_r))
		else $error("capture changed while protected");

	busy_flag_a: assert property (
		RD && hit(ADDR, PTSC_ADR_CTRL3)
		|=> RDATA[PTSC_C3_BUSY] == $past(counting_r))
		else $error("running flag misreported");

	cover_cmd_c: cover property (cmd_start ##1 PERIOD_IRQ);
	cover_trig_c: cover property (trig_start ##1 TRIG_START_IRQ);
	cover_defer_c: cover property (pending_r ##[1:1000] !counting_r);
	cover_cap_c: cover property (period_end && !prot_r && cap_mode);
endmodule
`default_nettype wire

// ==== ptsc_trig_src.sv ====
`timescale 1ns/1ps
`default_nettype none
////////////////////////////////////////////////////////////////////////
// far-side signal source on the trigger pin, with a chosen lag
module ptsc_trig_src (
	input wire logic clk,
	input wire logic lvl,
	input wire logic [3:0] dly,
	output logic pin
);
	logic [15:0] hist_r;
	always_ff @(posedge clk) begin
		hist_r <= {hist_r[14:0], lvl};
	end
	// zero lag answers at once; a long lag mimics a slow source
	assign pin = (dly == 4'h0) ? lvl : hist_r[dly - 4'h1];
endmodule
`default_nettype wire

// ==== tb.sv ====
`timescale 1ns/1ps
`default_nettype none
module tb;
	import ptsc_pkg::*;
	logic SYS_CLK = 1'b0;
	logic RST_N = 1'b0;
	logic WR = 1'b0;
	logic RD = 1'b0;
	logic lvl = 1'b0;
	logic [3:0] ADDR = 4'h0;
	logic [3:0] dly = 4'h0;
	logic [7:0] WDATA = 8'h00;
	logic [7:0] RDATA;
	logic [7:0] rv;
	logic TRIG_PIN, PULSE_A, PULSE_B, PERIOD_IRQ, TRIG_START_IRQ;
	int num_errors = 0;
	int check_count = 0;
	int cycles = 0;
	logic [15:0] na, nb, np, nt;
	logic [9:0] rs, fs;
	// reset table: index, value
	logic [11:0] regs [10] = '{12'h000, 12'h103, 12'h200, 12'h3ff,
		12'h403, 12'h500, 12'h602, 12'h800, 12'hb00, 12'h700};
	// ctrl1, ctrl2, high cycles of A and B in four periods
	logic [31:0] pat [5] = '{32'h00030c14, 32'h10031414, 32'h20030c0c,
		32'h00010c00, 32'h30002020};
	ptsc_top ptsc_top_inst (.SYS_CLK(SYS_CLK), .RST_N(RST_N), .ADDR(ADDR),
		.WDATA(WDATA), .WR(WR), .RD(RD), .RDATA(RDATA),
		.TRIG_PIN(TRIG_PIN), .PULSE_A(PULSE_A), .PULSE_B(PULSE_B),
		.PERIOD_IRQ(PERIOD_IRQ), .TRIG_START_IRQ(TRIG_START_IRQ));
	ptsc_trig_src ptsc_trig_src_inst (.clk(SYS_CLK), .lvl(lvl), .dly(dly),
		.pin(TRIG_PIN));
	initial begin
		forever #2.5 SYS_CLK = ~SYS_CLK;
	end
	////////////////////////////////////////////////////////////////////////
	task automatic chk(input logic [15:0] s, input logic [15:0] e);
		check_count++;
		if (s !== e) begin
			num_errors++;
			$display("BAD t=%0t seen=%h exp=%h", $time, s, e);
		end
	endtask
	task automatic wr(input logic [3:0] a, input logic [7:0] d);
		@(posedge SYS_CLK);
		WR <= 1'b1;
		ADDR <= a;
		WDATA <= d;
		@(posedge SYS_CLK);
		WR <= 1'b0;
	endtask
	task automatic rd(input logic [3:0] a);
		@(posedge SYS_CLK);
		RD <= 1'b1;
		ADDR <= a;
		@(posedge SYS_CLK);
		RD <= 1'b0;
		#1 rv = RDATA;
	endtask
	task automatic bz(input logic e);
		rd(PTSC_ADR_CTRL3);
		chk({15'h0000, rv[7]}, {15'h0000, e});
	endtask
	// counts output highs and pulses, sampled mid-cycle
	task automatic watch(input int n);
		na = 16'h0000;
		nb = 16'h0000;
		np = 16'h0000;
		nt = 16'h0000;
		repeat (n) begin
			#1;
			na = na + {15'h0000, PULSE_A};
			nb = nb + {15'h0000, PULSE_B};
			np = np + {15'h0000, PERIOD_IRQ};
			nt = nt + {15'h0000, TRIG_START_IRQ};
			@(posedge SYS_CLK);
		end
	endtask
	task automatic pin(input logic v);
		@(posedge SYS_CLK);
		lvl <= v;
	endtask
	task automatic pulse(input int w);
		pin(1'b1);
		repeat (w - 1) @(posedge SYS_CLK);
		pin(1'b0);
	endtask
	task automatic wait_irq();
		int k;
		k = 0;
		do begin
			@(posedge SYS_CLK);
			#1 k++;
		end while (PERIOD_IRQ !== 1'b1 && k < 200);
		if (k >= 200) num_errors++;
	endtask
	task automatic rdcap();
		rd(PTSC_ADR_RISE_LO);
		rs[7:0] = rv;
		rd(PTSC_ADR_RISE_HI);
		rs[9:8] = rv[1:0];
		rd(PTSC_ADR_FALL_LO);
		fs[7:0] = rv;
		rd(PTSC_ADR_FALL_HI);
		fs[9:8] = rv[1:0];
	endtask
	task automatic results();
		$display("checks %0d mismatches %0d", check_count, num_errors);
		if (num_errors == 0 && check_count > 0) $display("Result: passed");
		else $display("Result: failed");
		$finish;
	endtask
	// a hang ends the run as a mismatch
	always @(posedge SYS_CLK) begin
		cycles++;
		if (cycles == 6000) begin
			num_errors++;
			results();
		end
	end
	////////////////////////////////////////////////////////////////////////
	initial begin
		repeat (5) @(posedge SYS_CLK);
		RST_N <= 1'b1;
		@(posedge SYS_CLK);
		#1 chk({12'h000, PERIOD_IRQ, TRIG_START_IRQ, PULSE_A, PULSE_B},
			16'h0000);
		foreach (regs[i]) begin
			rd(regs[i][11:8]);
			chk({8'h00, rv}, {8'h00, regs[i][7:0]});
		end
		$display("test reset done");
		wr(PTSC_ADR_PER_LO, 8'h08);
		wr(PTSC_ADR_PER_HI, 8'h00);
		wr(PTSC_ADR_WID_LO, 8'h03);
		wr(PTSC_ADR_WID_HI, 8'h00);
		foreach (pat[i]) begin
			wr(PTSC_ADR_CTRL1, pat[i][31:24]);
			wr(PTSC_ADR_CTRL2, pat[i][23:16]);
			wr(PTSC_ADR_CTRL3, 8'h01);
			#1 chk({15'h0000, PERIOD_IRQ}, 16'h0001);
			@(posedge SYS_CLK);
			watch(32);
			chk(na, {8'h00, pat[i][15:8]});
			chk(nb, {8'h00, pat[i][7:0]});
			chk(np, 16'h0004);
			bz(1'b1);
			wr(PTSC_ADR_CTRL3, 8'h00);
			watch(16);
			#1 chk({14'h0000, PULSE_A, PULSE_B},
				{14'h0000, pat[i][28], pat[i][29]});
			chk(np, 16'h0000);
			bz(1'b0);
			$display("test row %0d done", i);
		end
		wr(PTSC_ADR_CTRL1, 8'h00);
		wr(PTSC_ADR_CTRL2, 8'h03);
		wr(PTSC_ADR_CTRL3, 8'h01);
		repeat (13) @(posedge SYS_CLK);
		wr(PTSC_ADR_CTRL3, 8'h02);
		@(posedge SYS_CLK);
		watch(10);
		chk(na + nb, 16'h000a);
		chk(np, 16'h0000);
		bz(1'b0);
		wr(PTSC_ADR_CTRL3, 8'h00);
		wr(PTSC_ADR_CTRL3, 8'h01);
		wr(PTSC_ADR_CTRL3, 8'h04);
		bz(1'b1);
		repeat (12) @(posedge SYS_CLK);
		// control stays untouched until the flag reads stopped
		bz(1'b0);
		wr(PTSC_ADR_CTRL3, 8'h00);
		$display("test stop modes done");
		// stop level is high for edge select 0, low for 1
		for (int e = 0; e < 2; e++) begin
			pin(e == 0);
			wr(PTSC_ADR_CTRL1, (e != 0) ? 8'h06 : 8'h02);
			repeat (4) @(posedge SYS_CLK);
			pin(e != 0);
			watch(8);
			chk(nt, 16'h0000);
			pin(e == 0);
			repeat (4) @(posedge SYS_CLK);
			wr(PTSC_ADR_CTRL3, 8'h01);
			watch(8);
			chk(np + nt, 16'h0000);
			bz(1'b0);
			pin(e != 0);
			watch(2);
			chk(nt, 16'h0000);
			watch(6);
			chk(nt, 16'h0001);
			bz(1'b1);
			pin(e == 0);
			repeat (4) @(posedge SYS_CLK);
			watch(8);
			chk(na + nb + np, 16'h0000);
			bz(1'b0);
			wr(PTSC_ADR_CTRL3, 8'h00);
		end
		// accept mode 1, only A enabled: stop waits for A inactive
		wr(PTSC_ADR_CTRL2, 8'h01);
		wr(PTSC_ADR_CTRL1, 8'h0a);
		wr(PTSC_ADR_CTRL3, 8'h01);
		pin(1'b1);
		repeat (4) @(posedge SYS_CLK);
		pin(1'b0);
		@(posedge SYS_CLK);
		pin(1'b1);
		watch(8);
		chk(nt, 16'h0001);
		chk(na, 16'h0003);
		chk(nb, 16'h0000);
		bz(1'b0);
		wr(PTSC_ADR_CTRL3, 8'h00);
		wr(PTSC_ADR_CTRL2, 8'h03);
		pin(1'b1);
		wr(PTSC_ADR_CTRL1, 8'h01);
		wr(PTSC_ADR_CTRL3, 8'h01);
		watch(8);
		chk(np, 16'h0000);
		bz(1'b0);
		pin(1'b0);
		watch(8);
		chk(nt, 16'h0001);
		wr(PTSC_ADR_CTRL3, 8'h00);
		wr(PTSC_ADR_CTRL3, 8'h01);
		#1 chk({15'h0000, PERIOD_IRQ}, 16'h0001);
		wr(PTSC_ADR_CTRL3, 8'h00);
		$display("test triggers done");
		// slow source: lag cancels in the edge-to-edge distance
		dly <= 4'h3;
		wr(PTSC_ADR_PER_LO, 8'h20);
		wr(PTSC_ADR_PER_HI, 8'h00);
		// one-time stop: a stop level ends the period at once
		wr(PTSC_ADR_CTRL3, 8'h01);
		wr(PTSC_ADR_CTRL3, 8'h04);
		pin(1'b1);
		repeat (6) @(posedge SYS_CLK);
		bz(1'b0);
		pin(1'b0);
		watch(8);
		chk(nt, 16'h0000);
		wr(PTSC_ADR_CTRL1, 8'h00);
		wr(PTSC_ADR_CTRL3, 8'h01);
		rdcap();
		wait_irq();
		pulse(6);
		wait_irq();
		wait_irq();
		rdcap();
		chk({6'h00, fs - rs}, 16'h0006);
		rd(PTSC_ADR_RISE_LO);
		wait_irq();
		pulse(4);
		wait_irq();
		wait_irq();
		rdcap();
		chk({6'h00, fs - rs}, 16'h0006);
		wait_irq();
		wait_irq();
		rdcap();
		chk({6'h00, fs - rs}, 16'h0004);
		wr(PTSC_ADR_CTRL3, 8'h00);
		$display("test capture done");
		results();
	end
endmodule
`default_nettype wire
